// >>> rtl/vslc_top.sv
// video serial link control: training, lane mapping, bit-error test
// How it works
// - route select low: receiver drives hot-plug and lock as open-drain
// - receiver releases hot-plug while powered down, else pulls it low
// - transmitter idles while hot-plug high, trains after it falls
// - receiver releases lock while unlocked, pulls it low once the shared lock line is high
// - transmitter trains until lock goes low, then sends video
// - route select high: same handshake carried over the sidelink
// - hot-plug not wired: transmitter takes hot-plug as always low
// - shared lock line joins lock status of all tied receivers
// - lane c bit 6 is data enable, bits 5..4 sync, rest video
// - every lane bit lands on the same lane and bit at receiver
// - 24-bit mode: lane d bit 6 unused, receiver drives it low
// - payload bits carried in blanking except first and last pixel
// - stereo left/right on lane e bit 6, enable on lane d bit 6
// - emphasis select low gives none, high gives full pre-emphasis
// - bit-error test only when entry set on both ends
// - test: pattern generated, encoded, scrambled and sent serially
// - test: checker drives data valid low on any bit error in the low 10 bits (the test symbol)
// - latch select high keeps errors sticky, low is live and clears
// - 24-bit mode disables lane e on both ends; transmitter still drives stereo_left_right_flag from lane e bit 6
// - link power-down low stops lanes and serial link
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module vslc_top #(
  parameter int ADDR_W = 4
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [ADDR_W-1:0]    s_awaddr,
  input  wire logic                 s_awvalid,
  output logic                      s_awready,
  input  wire logic [31:0]          s_wdata,
  input  wire logic [3:0]           s_wstrb,
  input  wire logic                 s_wvalid,
  output logic                      s_wready,
  output logic [1:0]                s_bresp,
  output logic                      s_bvalid,
  input  wire logic                 s_bready,
  input  wire logic [ADDR_W-1:0]    s_araddr,
  input  wire logic                 s_arvalid,
  output logic                      s_arready,
  output logic [31:0]               s_rdata,
  output logic [1:0]                s_rresp,
  output logic                      s_rvalid,
  input  wire logic                 s_rready,
  input  wire logic                 tx_hpd_i,
  input  wire logic                 tx_lock_i,
  input  wire logic                 sl_hpd_n,
  input  wire logic                 sl_lock_n,
  input  wire logic                 cdr_locked,
  input  wire logic                 shared_lock_line_i,
  output logic                      shared_lock_line_o,
  output logic                      shared_lock_line_oe,
  output logic                      hot_plug_detect_n_o,
  output logic                      hot_plug_detect_n_oe,
  output logic                      lock_detect_n_o,
  output logic                      lock_detect_n_oe,
  output logic                      sl_hpd_tx_n,
  output logic                      sl_lock_tx_n,
  input  wire vslc_pkg::vslc_lanes_s tx_lanes,
  output logic [34:0]               tx_word,
  output logic                      stereo_left_right_flag,
  output logic                      stereo_enable_flag,
  output logic                      tx_emphasis_full,
  input  wire logic [34:0]          rx_word,
  input  wire logic                 rx_stereo_lr,
  input  wire logic                 rx_stereo_en,
  output vslc_pkg::vslc_lanes_s     rx_lanes,
  output logic                      data_valid_out
);

  logic [6:0]                  ctrl;
  logic [vslc_pkg::SYNC_W-1:0] sync_a;
  logic [vslc_pkg::SYNC_W-1:0] sync_b;
  vslc_pkg::vslc_tx_e          tx_state;
  vslc_pkg::vslc_tx_e          next_tx_state;
  logic                        hpd_low;
  logic                        lock_low;
  logic                        rx_on;
  logic                        rx_bet;
  logic [34:0]                 in_q;
  logic                        de_prev;
  logic [15:0]                 tx_lfsr;
  logic                        tx_sym;
  logic [15:0]                 rx_lfsr;
  logic                        rx_sym;
  logic [1:0]                  rx_go;
  logic                        err_now;
  logic                        err_sticky;
  logic                        aw_full;
  logic                        w_full;
  logic [ADDR_W-1:0]           aw_addr;
  logic [31:0]                 w_data;
  logic [3:0]                  w_strb;

  // register select, shared by read and write decode
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'(vslc_pkg::CTRL_OFS))
      return 2'h1;
    if (a == ADDR_W'(vslc_pkg::STAT_OFS))
      return 2'h2;
    return 2'h0;
  endfunction

  // scrambler step, same polynomial at both ends
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[4] ^ s[3] ^ s[2]};
  endfunction

  // pre-encoded test symbol, scrambled by the low lfsr bits
  function automatic logic [9:0] test_sym(input logic       sel,
                                          input logic [15:0] s);
    return (sel ? vslc_pkg::SYM_B : vslc_pkg::SYM_A) ^ s[9:0];
  endfunction

  // two-stage synchroniser for the six status pin inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= vslc_pkg::SYNC_RST;
      sync_b <= vslc_pkg::SYNC_RST;
    end else begin
      sync_a <= {sl_lock_n, sl_hpd_n, cdr_locked,
                 shared_lock_line_i, tx_lock_i, tx_hpd_i};
      sync_b <= sync_a;
    end
  end

  // transmitter view of hot-plug and lock, by route
  always_comb begin
    if (ctrl[vslc_pkg::C_ROUTE]) begin
      hpd_low  = !sync_b[4];
      lock_low = !sync_b[5];
    end else begin
      hpd_low  = !ctrl[vslc_pkg::C_HPDW] || !sync_b[0];
      lock_low = !sync_b[1];
    end
  end

  assign rx_on  = ctrl[vslc_pkg::C_PDN];
  // both ends share one entry bit here
  assign rx_bet = rx_on && ctrl[vslc_pkg::C_BET];

  // transmitter training sequence
  always_comb begin
    next_tx_state = tx_state;
    if (!ctrl[vslc_pkg::C_PDN] || !hpd_low) begin
      next_tx_state = vslc_pkg::VSLC_TX_OFF;
    end else if (ctrl[vslc_pkg::C_BET]) begin
      next_tx_state = vslc_pkg::VSLC_TX_TEST;
    end else begin
      unique case (tx_state)
        vslc_pkg::VSLC_TX_OFF:   next_tx_state = vslc_pkg::VSLC_TX_TRAIN;
        vslc_pkg::VSLC_TX_TRAIN: if (lock_low) begin
          next_tx_state = vslc_pkg::VSLC_TX_VIDEO;
        end
        vslc_pkg::VSLC_TX_VIDEO: if (!lock_low) begin
          next_tx_state = vslc_pkg::VSLC_TX_TRAIN; // lost lock retrains
        end
        vslc_pkg::VSLC_TX_TEST:  next_tx_state = vslc_pkg::VSLC_TX_TRAIN;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      tx_state <= vslc_pkg::VSLC_TX_OFF;
    else
      tx_state <= next_tx_state;
  end

  // input lane stage; one cycle of look-ahead finds the last blank pixel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_q    <= '0;
      de_prev <= 1'b0;
      stereo_left_right_flag <= 1'b0;
      stereo_enable_flag     <= 1'b0;
    end else begin
      in_q    <= tx_lanes;
      de_prev <= in_q[vslc_pkg::DE_POS];
      stereo_left_right_flag <= tx_lanes.e[6];
      stereo_enable_flag     <= tx_lanes.d[6];
    end
  end

  // transmitter pattern generator, restarted on every test entry
  always_ff @(posedge aclk) begin
    if (!aresetn || tx_state != vslc_pkg::VSLC_TX_TEST) begin
      tx_lfsr <= vslc_pkg::LFSR_SEED;
      tx_sym  <= 1'b0;
    end else begin
      tx_lfsr <= lfsr_step(tx_lfsr);
      tx_sym  <= !tx_sym;
    end
  end

  // serial word: idle, training, test pattern or mapped lanes
  always_ff @(posedge aclk) begin
    logic [34:0] w;
    w = in_q;
    if (!in_q[vslc_pkg::DE_POS] &&
        (de_prev || tx_lanes.c[6]))
      w = w & ~vslc_pkg::PAYLOAD_MASK;
    if (ctrl[vslc_pkg::C_W24]) begin
      w[vslc_pkg::D6_POS] = 1'b0;
      w[34:vslc_pkg::E_LO] = '0;
    end
    if (!aresetn) begin
      tx_word <= '0;
    end else begin
      unique case (tx_state)
        vslc_pkg::VSLC_TX_OFF:   tx_word <= '0;
        vslc_pkg::VSLC_TX_TRAIN: tx_word <= {25'h0, vslc_pkg::TRAIN_SYM};
        vslc_pkg::VSLC_TX_VIDEO: tx_word <= w;
        vslc_pkg::VSLC_TX_TEST:
          tx_word <= {25'h0, test_sym(tx_sym, tx_lfsr)};
      endcase
    end
  end

  // emphasis only acts while the serial output is live
  always_ff @(posedge aclk) begin
    if (!aresetn)
      tx_emphasis_full <= 1'b0;
    else
      tx_emphasis_full <= ctrl[vslc_pkg::C_EMPH] &&
                          next_tx_state != vslc_pkg::VSLC_TX_OFF;
  end

  // receiver status pins; open-drain outputs only ever pull low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_lock_line_oe  <= 1'b0;
      hot_plug_detect_n_oe <= 1'b0;
      lock_detect_n_oe     <= 1'b0;
      sl_hpd_tx_n          <= 1'b1;
      sl_lock_tx_n         <= 1'b1;
    end else begin
      // any unlocked receiver holds the shared line low
      shared_lock_line_oe  <= rx_on && !sync_b[3];
      hot_plug_detect_n_oe <= rx_on && !ctrl[vslc_pkg::C_ROUTE];
      lock_detect_n_oe     <= rx_on && !ctrl[vslc_pkg::C_ROUTE] &&
                              sync_b[2];
      sl_hpd_tx_n          <= !(rx_on && ctrl[vslc_pkg::C_ROUTE]);
      sl_lock_tx_n         <= !(rx_on && ctrl[vslc_pkg::C_ROUTE] &&
                                sync_b[2]);
    end
  end

  assign shared_lock_line_o  = 1'b0;
  assign hot_plug_detect_n_o = 1'b0;
  assign lock_detect_n_o     = 1'b0;

  // receiver lane output
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_on) begin
      rx_lanes <= '0;
    end else begin
      rx_lanes   <= rx_word;
      rx_lanes.d[6] <= !ctrl[vslc_pkg::C_W24] && rx_stereo_en;
      rx_lanes.e <= ctrl[vslc_pkg::C_W24] ? 7'h00 :
                    {rx_stereo_lr, rx_word[33:vslc_pkg::E_LO]};
    end
  end

  // checker waits out the sender's two-cycle pattern start-up
  always_ff @(posedge aclk) begin
    if (!aresetn)
      rx_go <= '0;
    else
      rx_go <= {rx_go[0], rx_bet};
  end

  // receiver checker runs its own generator in step with the sender
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_bet || !rx_go[1]) begin
      rx_lfsr <= vslc_pkg::LFSR_SEED;
      rx_sym  <= 1'b0;
    end else begin
      rx_lfsr <= lfsr_step(rx_lfsr);
      rx_sym  <= !rx_sym;
    end
  end

  assign err_now = rx_bet && rx_go[1] &&
                   rx_word[9:0] != test_sym(rx_sym, rx_lfsr);

  // sticky error; a new error wins over the clearing level
  always_ff @(posedge aclk) begin
    if (!aresetn)
      err_sticky <= 1'b0;
    else
      err_sticky <= err_now ||
                    (err_sticky && ctrl[vslc_pkg::C_LATCH]);
  end

  // data valid: data enable in normal use, test verdict in test
  always_ff @(posedge aclk) begin
    if (!aresetn)
      data_valid_out <= 1'b0;
    else if (rx_bet)
      data_valid_out <= !err_now &&
        !(ctrl[vslc_pkg::C_LATCH] && err_sticky);
    else
      data_valid_out <= rx_on && rx_word[vslc_pkg::DE_POS];
  end

  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
      s_bvalid <= 1'b0;
      s_bresp  <= vslc_pkg::RESP_OK;
      ctrl     <= vslc_pkg::CTRL_RST;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_full <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      if (aw_full && w_full && !s_bvalid) begin
        s_bvalid <= 1'b1;
        s_bresp  <= reg_sel(aw_addr) == 2'h0 ? vslc_pkg::RESP_ERR :
                                                vslc_pkg::RESP_OK;
        if (reg_sel(aw_addr) == 2'h1 && w_strb[0])
          ctrl <= w_data[vslc_pkg::CTRL_W-1:0];
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        aw_full  <= 1'b0;
        w_full   <= 1'b0;
      end
    end
  end

  // ready stands high while the holding slot is empty
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
    end else begin
      s_awready <= !aw_full && !(s_awvalid && s_awready);
      s_wready  <= !w_full && !(s_wvalid && s_wready);
    end
  end

  // read channel; status shows the live link state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= '0;
      s_rresp   <= vslc_pkg::RESP_OK;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      s_rresp   <= vslc_pkg::RESP_OK;
      unique case (reg_sel(s_araddr))
        2'h1: s_rdata <= {25'h0, ctrl};
        2'h2: s_rdata <= {25'h0, lock_low, hpd_low, err_sticky,
                          sync_b[3], sync_b[2], tx_state};
        default: begin
          s_rdata <= '0;
          s_rresp <= vslc_pkg::RESP_ERR;
        end
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b1;
    end else if (!s_rvalid) begin
      s_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_hpd_release: assert property (
    !ctrl[vslc_pkg::C_PDN] |=> !hot_plug_detect_n_oe)
    else $error("hot-plug driven while powered down");
  chk_route_od: assert property (
    ctrl[vslc_pkg::C_ROUTE] |=> !hot_plug_detect_n_oe && !lock_detect_n_oe)
    else $error("status pins driven on sidelink route");
  chk_tx_idle: assert property (
    !hpd_low |=> tx_state == vslc_pkg::VSLC_TX_OFF)
    else $error("transmitter left idle without hot-plug");
  chk_train_hold: assert property (
    tx_state == vslc_pkg::VSLC_TX_TRAIN && !lock_low &&
    !ctrl[vslc_pkg::C_BET] && hpd_low && ctrl[vslc_pkg::C_PDN]
    |=> tx_state == vslc_pkg::VSLC_TX_TRAIN)
    else $error("training ended before lock");
  chk_lock_drive: assert property (
    rx_on && !ctrl[vslc_pkg::C_ROUTE] && !sync_b[2]
    |=> !lock_detect_n_oe)
    else $error("lock pulled while unlocked");
  chk_shared_line: assert property (
    rx_on && !sync_b[3] |=> shared_lock_line_oe)
    else $error("shared lock not pulled while unlocked");
  chk_d6_low: assert property (
    rx_on && ctrl[vslc_pkg::C_W24] |=> rx_lanes.d[6] == 1'b0 &&
    rx_lanes.e == 7'h00)
    else $error("lane d6 or lane e active in 24-bit mode");
  chk_lane_map: assert property (
    rx_on |=> rx_lanes.a == $past(rx_word[6:0]))
    else $error("lane a bits moved");
  chk_test_valid: assert property (
    rx_bet && err_now |=> !data_valid_out)
    else $error("bit error not reported");
  chk_sticky_err: assert property (
    rx_bet && ctrl[vslc_pkg::C_LATCH] && err_now ##1
    (rx_bet && ctrl[vslc_pkg::C_LATCH])[*2] |=> !data_valid_out)
    else $error("latched error lost");
  chk_emph_off: assert property (
    !ctrl[vslc_pkg::C_EMPH] |=> !tx_emphasis_full)
    else $error("emphasis on while deselected");
  chk_pdn_word: assert property (
    !ctrl[vslc_pkg::C_PDN] ##1 !ctrl[vslc_pkg::C_PDN]
    |=> tx_word == '0)
    else $error("serial word active while powered down");

  cov_video: cover property (
    tx_state == vslc_pkg::VSLC_TX_TRAIN ##1
    tx_state == vslc_pkg::VSLC_TX_VIDEO);
  cov_test_err: cover property (rx_bet && err_now);
  cov_sidelink: cover property (ctrl[vslc_pkg::C_ROUTE] && !sl_lock_tx_n);

endmodule

// >>> rtl/vslc_pkg.sv
// shared constants, types and carriers of the video serial link control
package vslc_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  // control fields
  localparam int C_PDN   = 0;
  localparam int C_ROUTE = 1;
  localparam int C_HPDW  = 2;
  localparam int C_EMPH  = 3;
  localparam int C_W24   = 4;
  localparam int C_BET   = 5;
  localparam int C_LATCH = 6;
  localparam int CTRL_W  = 7;
  localparam logic [6:0] CTRL_RST = 7'h04; // hot-plug wired, all else off
  // bus responses
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // lane layout, word bit = lane * 7 + bit, lanes a..e
  localparam int LANE_W = 7;
  localparam int WORD_W = 35;
  localparam int DE_POS = 20; // lane c bit 6
  localparam int D6_POS = 27; // lane d bit 6
  localparam int E_LO   = 28; // lane e bit 0
  localparam logic [34:0] PAYLOAD_MASK = 35'h7fe03f000;
  // test pattern symbols, both disparity neutral
  localparam logic [9:0] SYM_A     = 10'h2aa;
  localparam logic [9:0] SYM_B     = 10'h155;
  localparam logic [9:0] TRAIN_SYM = 10'h0f8;
  localparam logic [15:0] LFSR_SEED = 16'hffff;
  // synchronised inputs: sl_lock, sl_hpd, cdr, shared, lock, hpd
  localparam int SYNC_W = 6;
  localparam logic [5:0] SYNC_RST = 6'h3b;
  typedef enum logic [1:0] {
    VSLC_TX_OFF   = 2'b00,
    VSLC_TX_TRAIN = 2'b01,
    VSLC_TX_VIDEO = 2'b10,
    VSLC_TX_TEST  = 2'b11
  } vslc_tx_e;
  typedef struct packed {
    logic [6:0] e;
    logic [6:0] d;
    logic [6:0] c;
    logic [6:0] b;
    logic [6:0] a;
  } vslc_lanes_s;
endpackage

// >>> verification/vslc_far_end.sv
// far-side chip model: status lines, sidelink status, serial loop
`timescale 1ns/1ps
module vslc_far_end (
  input  wire logic        aclk,
  input  wire logic        plugged,
  input  wire logic        locked,
  input  wire logic        route_sl,
  input  wire logic        other_unl,
  input  wire logic        bit_err,
  input  wire logic        own_shared_oe,
  input  wire logic [34:0] tx_word,
  input  wire logic        lr_in,
  input  wire logic        en_in,
  output logic             hpd_line,
  output logic             lock_line,
  output logic             sl_hpd_n,
  output logic             sl_lock_n,
  output logic             cdr_locked,
  output logic             shared_line,
  output logic [34:0]      rx_word,
  output logic             rx_lr,
  output logic             rx_en
);
  logic lr_q = 1'b0;
  logic en_q = 1'b0;
  // dedicated lines float high on the pull-ups unless sunk
  assign hpd_line  = ~(plugged & ~route_sl);
  assign lock_line = ~(plugged & locked & ~route_sl);
  // sidelink carries the same handshake when routed there
  assign sl_hpd_n  = ~plugged;
  assign sl_lock_n = ~(plugged & locked);
  assign cdr_locked = locked;
  // wired-and: any unlocked receiver pulls the line down
  assign shared_line = ~(own_shared_oe | other_unl);
  // zero-latency loop, one flipped bit only on command
  assign rx_word = tx_word ^ {34'h0, bit_err};
  // unpacker flags realigned with the looped word
  always @(posedge aclk) begin
    lr_q <= lr_in;
    en_q <= en_in;
  end
  assign rx_lr = lr_q;
  assign rx_en = en_q;
endmodule

// >>> verification/vslc_top_tb.sv
// self-checking bench of the video serial link control
`timescale 1ns/1ps
module vslc_top_tb;
  typedef struct packed {
    logic [1:0]  resp;
    logic [31:0] data;
    logic [31:0] mask;
  } vslc_note_s;
  typedef struct packed {
    logic [34:0] tx;
    logic [34:0] care;
    logic [34:0] rx;
  } vslc_pix_s;
  logic                  aclk    = 1'b0;
  logic                  aresetn = 1'b0;
  logic [3:0]            awaddr  = 4'h0;
  logic [3:0]            araddr  = 4'h0;
  logic [31:0]           wdata   = 32'h0;
  logic [3:0]            wstrb   = 4'h0;
  logic                  awvalid = 1'b0;
  logic                  wvalid  = 1'b0;
  logic                  bready  = 1'b0;
  logic                  arvalid = 1'b0;
  logic                  rready  = 1'b0;
  logic                  plugged = 1'b0;
  logic                  locked  = 1'b0;
  logic                  route   = 1'b0;
  logic                  oth_unl = 1'b0;
  logic                  bit_err = 1'b0;
  logic                  drv     = 1'b0;
  logic                  w24_now = 1'b0;
  logic [2:0]            sh      = 3'h0;
  logic [15:0]           seed    = 16'h4c;
  vslc_pkg::vslc_lanes_s tx_lanes = '0;
  vslc_pkg::vslc_lanes_s lanes_d  = '0;
  vslc_pkg::vslc_lanes_s rx_lanes;
  logic                  s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]            s_bresp, s_rresp;
  logic [31:0]           s_rdata;
  logic                  hpd_i, lock_i, slh_n, sll_n, cdr, shr_i, shr_oe;
  logic                  hpd_oe, lock_oe, slh_tx_n, sll_tx_n, rx_lr, rx_en;
  logic [34:0]           tx_word, rx_word;
  logic                  lr_f, en_f, emph, dv, lo;
  int                    n_tests  = 0;
  int                    n_errors = 0;
  vslc_note_s            busq[$];
  vslc_pix_s             pixq[$];
  vslc_note_s            note;
  vslc_pix_s             prv;

  vslc_top dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
    .s_awvalid(awvalid), .s_awready(s_awready), .s_wdata(wdata),
    .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(rready), .tx_hpd_i(hpd_i), .tx_lock_i(lock_i),
    .sl_hpd_n(slh_n), .sl_lock_n(sll_n), .cdr_locked(cdr),
    .shared_lock_line_i(shr_i), .shared_lock_line_o(),
    .shared_lock_line_oe(shr_oe), .hot_plug_detect_n_o(),
    .hot_plug_detect_n_oe(hpd_oe), .lock_detect_n_o(),
    .lock_detect_n_oe(lock_oe), .sl_hpd_tx_n(slh_tx_n),
    .sl_lock_tx_n(sll_tx_n), .tx_lanes(tx_lanes), .tx_word(tx_word),
    .stereo_left_right_flag(lr_f), .stereo_enable_flag(en_f),
    .tx_emphasis_full(emph), .rx_word(rx_word), .rx_stereo_lr(rx_lr),
    .rx_stereo_en(rx_en), .rx_lanes(rx_lanes), .data_valid_out(dv));

  vslc_far_end far (.aclk(aclk), .plugged(plugged), .locked(locked),
    .route_sl(route), .other_unl(oth_unl), .bit_err(bit_err),
    .own_shared_oe(shr_oe), .tx_word(tx_word), .lr_in(lr_f),
    .en_in(en_f), .hpd_line(hpd_i), .lock_line(lock_i),
    .sl_hpd_n(slh_n), .sl_lock_n(sll_n), .cdr_locked(cdr),
    .shared_line(shr_i), .rx_word(rx_word), .rx_lr(rx_lr),
    .rx_en(rx_en));

  initial forever #2.5 aclk = ~aclk;

  task automatic cmp_word(input logic [34:0] got, exp, care);
    n_tests++;
    if ((got & care) !== (exp & care)) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, exp);
    cmp_word({34'h0, got}, {34'h0, exp}, '1);
  endtask
  // random lane data, 16-bit shift register run three steps
  function automatic logic [34:0] rnd35();
    logic [47:0] r;
    for (int k = 0; k < 3; k++) begin
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      r = {r[31:0], seed};
    end
    return r[34:0];
  endfunction
  // write: address and data offered together, held until each is taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic done;
    @(posedge aclk);
    busq.push_back('{r, 32'h0, 32'h0});
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && s_awready) awvalid <= 1'b0;
      if (wvalid && s_wready) wvalid <= 1'b0;
      if (s_bvalid) begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [1:0] r,
                    input logic [31:0] d, m);
    logic done;
    @(posedge aclk);
    busq.push_back('{r, d, m});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && s_arready) arvalid <= 1'b0;
      if (s_rvalid) begin
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // control write, then time for the synchronisers to settle
  task automatic ctl(input logic [31:0] v);
    wr(vslc_pkg::CTRL_OFS, v, vslc_pkg::RESP_OK);
    repeat (8) @(posedge aclk);
  endtask
  task automatic st(input logic [31:0] d, m);
    rd(vslc_pkg::STAT_OFS, vslc_pkg::RESP_OK, d, m);
  endtask
  // 20 pixels, data enable two high then three low
  task automatic stream(input logic w24);
    logic [34:0] px [20];
    vslc_pix_s   p;
    w24_now = w24;
    for (int i = 0; i < 20; i++) begin
      px[i] = rnd35();
      px[i][vslc_pkg::DE_POS] = (i % 5) < 2;
      p.tx = px[i];
      if (i % 5 == 2 || i % 5 == 4) p.tx &= ~vslc_pkg::PAYLOAD_MASK;
      p.care = w24 ? 35'h7ffffff : '1;
      // stereo flags travel beside the word, never blanked
      p.rx = w24 ? (p.tx & 35'h7ffffff) :
             {px[i][34], p.tx[33:28], px[i][27], p.tx[26:0]};
      pixq.push_back(p);
    end
    for (int i = 0; i < 20; i++) begin
      tx_lanes <= px[i];
      drv <= 1'b1;
      @(posedge aclk);
    end
    tx_lanes <= 35'h100000;
    drv <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  // one flipped bit, then note whether data valid dropped
  task automatic inject(output logic low_seen);
    bit_err <= 1'b1;
    @(posedge aclk);
    bit_err <= 1'b0;
    low_seen = 1'b0;
    repeat (6) begin
      @(negedge aclk);
      if (dv === 1'b0) low_seen = 1'b1;
    end
    @(posedge aclk);
  endtask
  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // bus answers: oldest note against each handshake
  always @(posedge aclk) begin
    if ((s_rvalid && rready) || (s_bvalid && bready)) begin
      note = busq.pop_front();
      if (s_rvalid) begin
        cmp_word({1'b0, s_rresp, s_rdata & note.mask},
          {1'b0, note.resp, note.data & note.mask}, '1);
      end else begin
        cmp_word({33'h0, s_bresp}, {33'h0, note.resp}, '1);
      end
    end
  end
  // stream watch: flags lag one, word two, receiver lanes three
  always @(posedge aclk) begin
    sh <= {sh[1:0], drv};
    lanes_d <= tx_lanes;
  end
  always @(negedge aclk) begin
    if (sh[0] && !w24_now) begin
      cmp_bit(lr_f, lanes_d.e[6]);
      cmp_bit(en_f, lanes_d.d[6]);
    end
    if (sh[2]) begin
      cmp_word(rx_lanes, prv.rx, '1);
      cmp_bit(dv, prv.tx[vslc_pkg::DE_POS]);
    end
    if (sh[1]) begin
      prv = pixq.pop_front();
      cmp_word(tx_word, prv.tx, prv.care);
    end
  end

  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(vslc_pkg::CTRL_OFS, vslc_pkg::RESP_OK, 32'h4, '1);
    rd(4'h8, vslc_pkg::RESP_ERR, 32'h0, '1);
    wr(4'h8, 32'h7f, vslc_pkg::RESP_ERR);
    wr(vslc_pkg::STAT_OFS, 32'h3, vslc_pkg::RESP_OK);
    st(32'h0, 32'h3);
    $display("test registers done");
    ctl(32'h5);
    cmp_bit(hpd_oe, 1'b1);
    st(32'h0, 32'h3);
    plugged <= 1'b1;
    repeat (8) @(posedge aclk);
    st(32'h1, 32'h3);
    cmp_word(tx_word, {25'h0, vslc_pkg::TRAIN_SYM}, 35'h3ff);
    cmp_bit(lock_oe, 1'b0);
    locked <= 1'b1;
    repeat (8) @(posedge aclk);
    cmp_bit(lock_oe, 1'b1);
    st(32'h2, 32'h3);
    oth_unl <= 1'b1;
    repeat (8) @(posedge aclk);
    cmp_bit(lock_oe, 1'b0);
    oth_unl <= 1'b0;
    repeat (8) @(posedge aclk);
    $display("test training done");
    stream(1'b0);
    ctl(32'h15);
    stream(1'b1);
    $display("test lanes done");
    for (int e = 1; e >= 0; e--) begin
      ctl(32'h5 | (e << 3));
      cmp_bit(emph, e[0]);
    end
    ctl(32'h25);
    st(32'h3, 32'h3);
    cmp_bit(dv, 1'b1);
    inject(lo);
    cmp_bit(lo, 1'b1);
    cmp_bit(dv, 1'b1);
    ctl(32'h65);
    inject(lo);
    repeat (4) @(posedge aclk);
    cmp_bit(dv, 1'b0);
    st(32'h10, 32'h10);
    ctl(32'h25);
    cmp_bit(dv, 1'b1);
    $display("test bit error done");
    ctl(32'h0);
    cmp_word(tx_word, 35'h0, '1);
    cmp_bit(hpd_oe, 1'b0);
    st(32'h0, 32'h3);
    plugged <= 1'b0;
    locked <= 1'b0;
    ctl(32'h1);
    st(32'h1, 32'h3);
    route <= 1'b1;
    plugged <= 1'b1;
    locked <= 1'b1;
    ctl(32'h7);
    st(32'h2, 32'h3);
    cmp_bit(slh_tx_n, 1'b0);
    $display("test power and route done");
    give_verdict();
  end
endmodule
